/* rtl/motor_start_map.svh */
// constants of the start sequencer
`ifndef MOTOR_START_MAP_SVH
`define MOTOR_START_MAP_SVH
`define START_DIRECT 2'h0
`define START_TRACK 2'h1
`define START_PREEXC 2'h2
`define ORIGIN_STOP 2'h0
`define ORIGIN_ZERO 2'h1
`define ORIGIN_MAX 2'h2
`define RATE_MIN 7'h01
`define RATE_MAX 7'h64
`define LAUNCH_FREQ_MAX 16'h03e8
`define PHASE_TIME_MAX 11'h03e8
`define CURRENT_PCT_MAX 7'h64
`define BASE_LIMIT_PCT 8'h50
`define TICK_TIME_MS 32'h0000_0064
`define CLK_MHZ 32'h0000_00c8
`endif

/* rtl/motor_start_pkg.sv */
// types of the start sequencer
`default_nettype none
package motor_start_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_BRAKE, ST_EXCITE, ST_TRACK, ST_HOLD, ST_ACCEL
	} phase_e;
endpackage
`default_nettype wire

/* rtl/motor_start_sequencer.sv */
// start-control sequencer of an ac motor drive
// Summary of operation
// - start method 0 direct, 1 speed tracking, 2 pre-excited; others act as direct.
// - direct start with zero braking time runs at once at launch frequency.
// - direct start with nonzero braking time brakes first, then runs.
// - tracking restart finds speed and direction, then starts at tracked frequency.
// - pre-excitation only for asynchronous motors; zero time skips it.
// - nonzero pre-excitation time builds the field for that time first.
// - tracking origin 0 stop frequency, 1 zero, 2 maximum; others as 0.
// - tracking rate 1 to 100, default 20; larger tracks faster.
// - launch frequency 0 to 10 Hz held for hold time 0 to 100 s.
// - launch frequency is not clamped by the lower frequency limit.
// - target below launch frequency keeps standby with zero output frequency.
// - no launch hold during forward/reverse changeover.
// - hold time excluded from acceleration time, counted in step sequencer run time.
// - one current level and one duration serve braking and pre-excitation.
// - current base is motor rating, or 80 % of drive rating if that is smaller.
// - start braking only in direct start.
`default_nettype none
`include "motor_start_map.svh"
module motor_start_sequencer #(
	parameter int unsigned TICK_CYCLES = `TICK_TIME_MS * `CLK_MHZ * 1000,
	parameter int unsigned FREQ_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run_cmd,
	input wire logic reverse_cmd,
	input wire logic async_motor,
	input wire logic [1:0] start_method_select,
	input wire logic [1:0] tracking_origin_select,
	input wire logic [6:0] tracking_rate,
	input wire logic [FREQ_W-1:0] launch_frequency,
	input wire logic [10:0] launch_hold_time,
	input wire logic [6:0] launch_current_level,
	input wire logic [10:0] launch_phase_duration,
	input wire logic [FREQ_W-1:0] target_frequency,
	input wire logic [FREQ_W-1:0] stop_frequency,
	input wire logic [FREQ_W-1:0] max_frequency,
	input wire logic [FREQ_W-1:0] motor_frequency,
	input wire logic motor_reverse,
	input wire logic speed_found,
	input wire logic [15:0] motor_rated_current,
	input wire logic [15:0] drive_rated_current,
	output logic [FREQ_W-1:0] out_frequency,
	output logic out_reverse,
	output logic dc_brake_on,
	output logic excite_on,
	output logic [15:0] current_ref,
	output logic tracking_on,
	output logic [FREQ_W-1:0] track_frequency,
	output logic [6:0] track_step,
	output logic standby,
	output logic accel_enable,
	output logic accel_time_count,
	output logic step_time_count
);
	typedef struct packed {
		motor_start_pkg::phase_e phase;
		logic [10:0] cnt;
		logic run_d1;
		logic last_rev;
		logic [FREQ_W-1:0] freq;
		logic rev;
		logic [15:0] cur;
		logic [FREQ_W-1:0] trk;
		logic [6:0] step;
		logic standby;
		logic brake;
		logic excite;
		logic tracking;
		logic accel;
		logic steps;
	} seq_s;
	seq_s q, d;
	logic tick;
	logic clear_tick;

	// clamp a 0.1 s duration to its legal maximum
	function automatic logic [10:0] lim_time(input logic [10:0] t);
		lim_time = (t > `PHASE_TIME_MAX) ? `PHASE_TIME_MAX : t;
	endfunction

	// braking or excitation current from the shared percentage
	function automatic logic [15:0] phase_current(input logic [6:0] pct,
		input logic [15:0] mot, input logic [15:0] drv);
		logic [31:0] base;
		logic [6:0] p;
		base = ({16'h0000, mot} * 32'h0000_0064 <= {16'h0000, drv} * {24'h00_0000, `BASE_LIMIT_PCT})
			? {16'h0000, mot} : ({16'h0000, drv} * {24'h00_0000, `BASE_LIMIT_PCT}) / 32'h0000_0064;
		p = (pct > `CURRENT_PCT_MAX) ? `CURRENT_PCT_MAX : pct;
		phase_current = 16'((base * {25'h000_0000, p}) / 32'h0000_0064);
	endfunction

	tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_div (
		.clk(clk),
		.rst(rst),
		.clear(clear_tick),
		.tick(tick)
	);

	assign clear_tick = (q.phase == motor_start_pkg::ST_IDLE);

	always_comb begin
		logic [FREQ_W-1:0] lf;
		logic [6:0] rate;
		lf = (launch_frequency > FREQ_W'(`LAUNCH_FREQ_MAX)) ? FREQ_W'(`LAUNCH_FREQ_MAX)
			: launch_frequency;
		rate = (tracking_rate < `RATE_MIN) ? `RATE_MIN
			: (tracking_rate > `RATE_MAX) ? `RATE_MAX : tracking_rate;
		d = q;
		d.run_d1 = run_cmd;
		d.step = rate;
		if (!run_cmd) begin
			d.phase = motor_start_pkg::ST_IDLE;
			d.freq = '0;
			d.cur = '0;
			d.standby = 1'b1;
		end else begin
			case (q.phase)
				motor_start_pkg::ST_IDLE: begin
					d.freq = '0;
					if (target_frequency < lf) begin
						d.standby = 1'b1;
					end else begin
						d.standby = 1'b0;
						d.rev = reverse_cmd;
						d.cnt = lim_time(launch_phase_duration);
						d.cur = phase_current(launch_current_level,
							motor_rated_current, drive_rated_current);
						if (start_method_select == `START_TRACK) begin
							d.phase = motor_start_pkg::ST_TRACK;
							d.cur = '0;
							if (tracking_origin_select == `ORIGIN_ZERO) begin
								d.trk = '0;
							end else if (tracking_origin_select == `ORIGIN_MAX) begin
								d.trk = max_frequency;
							end else begin
								d.trk = stop_frequency;
							end
						end else if (start_method_select == `START_PREEXC) begin
							if (async_motor && launch_phase_duration != 11'h000) begin
								d.phase = motor_start_pkg::ST_EXCITE;
							end else begin
								d.phase = motor_start_pkg::ST_HOLD;
								d.cnt = lim_time(launch_hold_time);
								d.freq = lf;
								d.cur = '0;
							end
						end else if (launch_phase_duration != 11'h000) begin
							d.phase = motor_start_pkg::ST_BRAKE;
						end else begin
							d.phase = motor_start_pkg::ST_HOLD;
							d.cnt = lim_time(launch_hold_time);
							d.freq = lf;
							d.cur = '0;
						end
					end
				end
				motor_start_pkg::ST_BRAKE, motor_start_pkg::ST_EXCITE: begin
					if (tick) begin
						if (q.cnt <= 11'h001) begin
							d.phase = motor_start_pkg::ST_HOLD;
							d.cnt = lim_time(launch_hold_time);
							d.freq = lf;
							d.cur = '0;
						end else begin
							d.cnt = q.cnt - 11'h001;
						end
					end
				end
				motor_start_pkg::ST_TRACK: begin
					if (speed_found) begin
						d.phase = motor_start_pkg::ST_ACCEL;
						d.freq = motor_frequency;
						d.rev = motor_reverse;
					end else if (tick) begin
						// sweep toward the motor frequency, faster at higher rates
						if (q.trk > motor_frequency + FREQ_W'(rate)) begin
							d.trk = q.trk - FREQ_W'(rate);
						end else if (q.trk + FREQ_W'(rate) < motor_frequency) begin
							d.trk = q.trk + FREQ_W'(rate);
						end else begin
							d.trk = motor_frequency;
						end
					end
				end
				motor_start_pkg::ST_HOLD: begin
					d.freq = lf;
					if (q.cnt == 11'h000 || (reverse_cmd != q.last_rev)) begin
						d.phase = motor_start_pkg::ST_ACCEL;
					end else if (tick) begin
						d.cnt = q.cnt - 11'h001;
					end
				end
				motor_start_pkg::ST_ACCEL: begin
					d.freq = q.freq;
					d.rev = reverse_cmd;
				end
				default: begin
					d.phase = motor_start_pkg::ST_IDLE;
				end
			endcase
		end
		d.last_rev = reverse_cmd;
		// phase flags registered so every output leaves a flip-flop
		d.brake = (d.phase == motor_start_pkg::ST_BRAKE);
		d.excite = (d.phase == motor_start_pkg::ST_EXCITE);
		d.tracking = (d.phase == motor_start_pkg::ST_TRACK);
		d.accel = (d.phase == motor_start_pkg::ST_ACCEL);
		d.steps = (d.phase == motor_start_pkg::ST_HOLD) || d.accel;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.phase <= motor_start_pkg::ST_IDLE;
			q.standby <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign out_frequency = q.freq;
	assign out_reverse = q.rev;
	assign dc_brake_on = q.brake;
	assign excite_on = q.excite;
	assign current_ref = q.cur;
	assign tracking_on = q.tracking;
	assign track_frequency = q.trk;
	assign track_step = q.step;
	assign standby = q.standby;
	assign accel_enable = q.accel;
	assign accel_time_count = q.accel;
	assign step_time_count = q.steps;
endmodule
`default_nettype wire

/* rtl/tick_divider.sv */
// divider giving one enable pulse per 0.1 s
`default_nettype none
`include "motor_start_map.svh"
module tick_divider #(
	parameter int unsigned TICK_CYCLES = `TICK_TIME_MS * `CLK_MHZ * 1000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} div_s;
	div_s q, d;
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (clear) begin
			d.cnt = '0;
		end else if (q.cnt >= TICK_CYCLES - 1) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 32'h0000_0001;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign tick = q.tick;
endmodule
`default_nettype wire

/* testbench/motor_stage_model.sv */
// motor stage model answering speed searches
`default_nettype none
module motor_stage_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic tracking_on,
	input wire logic [3:0] found_delay,
	output logic [15:0] motor_frequency,
	output logic motor_reverse,
	output logic speed_found
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) wait_q <= 4'h0;
		else if (!tracking_on) wait_q <= 4'h0;
		else wait_q <= wait_q + 4'h1;
	end
	assign speed_found = tracking_on && wait_q == found_delay;
	// result only valid with the found pulse; motor found turning in reverse
	assign motor_frequency = speed_found ? 16'h0320 : ~16'h0320;
	assign motor_reverse = speed_found;
endmodule
`default_nettype wire

/* testbench/motor_start_sequencer_checker.sv */
// port assertions of the start sequencer
`default_nettype none
module motor_start_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic run_cmd,
	input wire logic async_motor,
	input wire logic [1:0] start_method_select,
	input wire logic [15:0] launch_frequency,
	input wire logic [10:0] launch_phase_duration,
	input wire logic [15:0] target_frequency,
	input wire logic [15:0] motor_frequency,
	input wire logic speed_found,
	input wire logic [15:0] out_frequency,
	input wire logic dc_brake_on,
	input wire logic excite_on,
	input wire logic tracking_on,
	input wire logic standby,
	input wire logic accel_enable,
	input wire logic accel_time_count,
	input wire logic step_time_count
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_standby_zero: assert property (standby |-> out_frequency == 16'h0000)
		else $error("frequency while standby");
	chk_low_target: assert property (standby && run_cmd && target_frequency < launch_frequency
		|=> standby) else $error("started below launch frequency");
	chk_direct_start: assert property (standby && run_cmd && start_method_select == 2'h0
		&& launch_phase_duration == 11'h000 && target_frequency >= launch_frequency
		|=> step_time_count && !accel_time_count && out_frequency == $past(launch_frequency))
		else $error("direct start not at launch frequency");
	chk_brake_direct: assert property (dc_brake_on |-> start_method_select inside {2'h0, 2'h3})
		else $error("braking outside direct start");
	chk_excite_async: assert property (excite_on |-> async_motor && start_method_select == 2'h2)
		else $error("field build not allowed");
	chk_one_phase: assert property (
		$onehot0({dc_brake_on, excite_on, tracking_on, step_time_count}))
		else $error("phases overlap");
	chk_track_found: assert property (run_cmd && tracking_on && speed_found
		|=> accel_enable && out_frequency == $past(motor_frequency)) else $error("tracked start");
	chk_accel_count: assert property (accel_time_count |-> accel_enable && step_time_count)
		else $error("time counting wrong");
	cov_brake: cover property (dc_brake_on ##1 !dc_brake_on);
	cov_excite: cover property (excite_on);
	cov_track: cover property (tracking_on && speed_found);
endmodule
bind motor_start_sequencer motor_start_checker u_chk (.clk, .rst, .run_cmd, .async_motor,
	.start_method_select, .launch_frequency, .launch_phase_duration, .target_frequency,
	.motor_frequency, .speed_found, .out_frequency, .dc_brake_on, .excite_on, .tracking_on,
	.standby, .accel_enable, .accel_time_count, .step_time_count);
`default_nettype wire

/* testbench/test_motor_start_sequencer.sv */
// self-checking bench of the start sequencer
`default_nettype none
module test_motor_start_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, run_cmd = 1'h0, reverse_cmd = 1'h0, async_motor = 1'h0;
	logic [1:0] start_method_select = 2'h0, tracking_origin_select = 2'h0;
	logic [6:0] tracking_rate = 7'h14, launch_current_level = 7'h28;
	logic [10:0] launch_hold_time = 11'h000, launch_phase_duration = 11'h000;
	logic [15:0] launch_frequency = 16'h01f4, target_frequency = 16'h03e8;
	logic [15:0] stop_frequency = 16'h0190, max_frequency = 16'h1388;
	logic [15:0] motor_rated_current = 16'h01f4, drive_rated_current = 16'h03e8;
	logic [15:0] motor_frequency, out_frequency, current_ref, track_frequency;
	logic motor_reverse, speed_found, dc_brake_on, excite_on, tracking_on, standby;
	logic accel_enable, accel_time_count, step_time_count, out_reverse;
	logic [6:0] track_step;
	logic [3:0] found_delay = 4'h1;
	logic [15:0] origin_exp [3] = '{16'h0190, 16'h0000, 16'h1388};
	int errors = 0, n_compared = 0, cycles = 0;
	motor_start_sequencer #(.TICK_CYCLES(4)) u_dut (.clk, .rst, .run_cmd, .reverse_cmd,
		.async_motor, .start_method_select, .tracking_origin_select, .tracking_rate,
		.launch_frequency, .launch_hold_time, .launch_current_level, .launch_phase_duration,
		.target_frequency, .stop_frequency, .max_frequency, .motor_frequency, .motor_reverse,
		.speed_found, .motor_rated_current, .drive_rated_current, .out_frequency,
		.out_reverse, .dc_brake_on, .excite_on, .current_ref, .tracking_on, .track_frequency,
		.track_step, .standby, .accel_enable, .accel_time_count, .step_time_count);
	motor_stage_model u_motor (.clk, .rst, .tracking_on, .found_delay, .motor_frequency,
		.motor_reverse, .speed_found);
	always #2.5 clk = ~clk;
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task start(input logic [1:0] m, input logic [10:0] d, input logic [10:0] h);
		@(posedge clk);
		start_method_select <= m;
		launch_phase_duration <= d;
		launch_hold_time <= h;
		run_cmd <= 1'b1;
		@(posedge clk);
		#1;
	endtask
	task halt;
		@(posedge clk);
		run_cmd <= 1'b0;
		reverse_cmd <= 1'b0;
		target_frequency <= 16'h03e8;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task wait_accel;
		repeat (200) if (accel_enable !== 1'b1) @(negedge clk);
	endtask
	task final_report;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		target_frequency <= 16'h00c8;
		start(2'h0, 11'h000, 11'h000);
		check(standby, 16'h0001);
		check(out_frequency, 16'h0000);
		halt;
		$display("standby test done");
		for (int m = 0; m < 4; m += 3) begin
			start(m[1:0], 11'h000, 11'h002);
			check(out_frequency, 16'h01f4);
			repeat (3) @(negedge clk);
			check(accel_enable, 16'h0000);
			check(step_time_count, 16'h0001);
			wait_accel;
			check(accel_time_count, 16'h0001);
			halt;
		end
		$display("direct start test done");
		start(2'h0, 11'h002, 11'h000);
		check(dc_brake_on, 16'h0001);
		check(current_ref, 16'h00c8);
		wait_accel;
		check(out_frequency, 16'h01f4);
		halt;
		$display("start braking test done");
		for (int o = 0; o < 3; o++) begin
			@(posedge clk);
			tracking_origin_select <= o[1:0];
			found_delay <= o[0] ? 4'h8 : 4'h1;
			start(2'h1, 11'h002, 11'h000);
			check(dc_brake_on, 16'h0000);
			check(track_frequency, origin_exp[o]);
			check(track_step, 16'h0014);
			wait_accel;
			check(out_frequency, 16'h0320);
			check(out_reverse, 16'h0001);
			halt;
		end
		$display("tracking test done");
		@(posedge clk);
		async_motor <= 1'b1;
		motor_rated_current <= 16'h0384;
		start(2'h2, 11'h002, 11'h000);
		check(excite_on, 16'h0001);
		check(current_ref, 16'h0140);
		halt;
		@(posedge clk);
		async_motor <= 1'b0;
		start(2'h2, 11'h002, 11'h000);
		check(excite_on, 16'h0000);
		check(step_time_count, 16'h0001);
		halt;
		$display("field build test done");
		start(2'h0, 11'h000, 11'h014);
		@(posedge clk);
		reverse_cmd <= 1'b1;
		repeat (3) @(negedge clk);
		check(accel_enable, 16'h0001);
		halt;
		$display("reversal test done");
		final_report;
	end
endmodule
`default_nettype wire
